/* File: slpc_pkg.sv */
// constants for the s0 low-power level controller
// assumes a single 200 MHz crystal-derived system clock
package slpc_pkg;

    // ********************************************************
    // clock and timing
    // ********************************************************
    localparam int CLK_PERIOD_PS = 5000;
    localparam int RESTORE_NS = 1000;
    localparam int RESTORE_CYC = (RESTORE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int IDLE_QUAL_NS = 100;
    localparam int IDLE_QUAL_CYC = (IDLE_QUAL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // ********************************************************
    // processor package c-state codes and sizes
    // ********************************************************
    localparam int CSTATE_W = 4;
    localparam logic [3:0] CSTATE_C0 = 4'h0;
    localparam logic [3:0] CSTATE_C6 = 4'h6;
    localparam logic [3:0] CSTATE_C10 = 4'hA;
    localparam int NUM_IF = 4;
    localparam int NUM_LANES = 8;
    localparam int NUM_CLKREQ = 4;

    // ********************************************************
    // level reported to the platform
    // ********************************************************
    localparam logic [1:0] LEVEL_EXIT = 2'h0;
    localparam logic [1:0] LEVEL_ONE = 2'h1;
    localparam logic [1:0] LEVEL_TWO = 2'h2;
    localparam logic [1:0] LEVEL_THREE = 2'h3;

    typedef enum logic [1:0] {
        ST_LEVEL_ONE = 2'b00,
        ST_LEVEL_TWO = 2'b01,
        ST_LEVEL_THREE = 2'b10,
        ST_EXIT = 2'b11
    } slpc_state_type;

endpackage : slpc_pkg

/* File: slpc_idle_gate.sv */
// per-unit idle gate: shuts one pll or lane down once its own idle holds
// assumes idle and allow come from logic on the same clock
`timescale 1ns/100ps
module slpc_idle_gate #(
    parameter int QUAL_CYC = slpc_pkg::IDLE_QUAL_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic idle,
    input wire logic allow,
    output logic gate_off
);

    localparam int CNT_W = $clog2(QUAL_CYC + 1);
    localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(QUAL_CYC);

    logic [CNT_W-1:0] qual_cnt_r;
    logic gate_off_r;

    // ********************************************************
    // idle qualification
    // ********************************************************
    // a short idle blip must not gate, so idle is counted before acting
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            qual_cnt_r <= '0;
        end else if (!idle || !allow) begin
            qual_cnt_r <= '0;
        end else if (qual_cnt_r != CNT_MAX) begin
            qual_cnt_r <= qual_cnt_r + CNT_W'(1);
        end
    end

    // each unit decides alone, no global flow
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            gate_off_r <= 1'b0;
        end else begin
            gate_off_r <= idle && allow && (qual_cnt_r == CNT_MAX);
        end
    end

    assign gate_off = gate_off_r;

    // ********************************************************
    // checks
    // ********************************************************
    own_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(gate_off_r) |-> $past(idle) && $past(allow))
        else $error("unit gated without its own idle");
    wake_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !idle |=> !gate_off_r)
        else $error("unit stayed gated after leaving idle");

endmodule : slpc_idle_gate

/* File: slpc_top.sv */
// s0 low-power level controller: levels one to three, crystal gate, idle-floor pin
// assumes processor pins and clock requests arrive asynchronously,
// interface and lane idle flags come from controllers on CLK_SYS
//
// How it works
// - controllers gate themselves; levels only summarise
// - level one: link l1, pll, controller, lane gating
// - c6 or deeper adds main and overclock pll off
// - c10 level three adds crystal off, indicator
// - crystal off needs c10, level three, no requests
// - each interface pll shuts down on own idle
// - lane power gating independent per lane
// - indicator is active-low hardware-driven output
// - indicator high in s0, low only when criteria
`timescale 1ns/100ps
module slpc_top #(
    parameter int NUM_IF = slpc_pkg::NUM_IF,
    parameter int NUM_LANES = slpc_pkg::NUM_LANES,
    parameter int NUM_CLKREQ = slpc_pkg::NUM_CLKREQ,
    parameter int RESTORE_CYC = slpc_pkg::RESTORE_CYC,
    parameter int IDLE_QUAL_CYC = slpc_pkg::IDLE_QUAL_CYC
) (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic [slpc_pkg::CSTATE_W-1:0] PROCESSOR_PKG_CSTATE,
    input wire logic PROCESSOR_DEEP_IDLE_GATE_N,
    input wire logic [NUM_CLKREQ-1:0] CRYSTAL_CLKREQ,
    input wire logic [NUM_IF-1:0] IF_IDLE,
    input wire logic [NUM_LANES-1:0] LANE_IDLE,
    input wire logic WAKE_REQ,
    output logic [1:0] LOW_POWER_LEVEL,
    output logic CHIP_LINK_L1_ALLOW,
    output logic [NUM_IF-1:0] IF_PLL_OFF,
    output logic [NUM_LANES-1:0] LANE_POWER_GATE,
    output logic MAIN_PLL_OFF,
    output logic OVERCLOCK_PLL_OFF,
    output logic REFERENCE_CRYSTAL_OFF,
    output logic IDLE_FLOOR_INDICATOR_N,
    output logic RESUME_GRANT
);

    localparam int CNT_W = $clog2(RESTORE_CYC + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(RESTORE_CYC - 1);
    localparam int EXIT_MAX = RESTORE_CYC + 3;

    // ********************************************************
    // input synchronisers
    // ********************************************************
    // cstate is a multi-bit code; the processor holds it steady between messages
    logic [slpc_pkg::CSTATE_W-1:0] cst_m_r, cst_s_r;
    logic gate_n_m_r, gate_n_s_r;
    logic [NUM_CLKREQ-1:0] req_m_r, req_s_r;

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            cst_m_r <= slpc_pkg::CSTATE_C0;
            cst_s_r <= slpc_pkg::CSTATE_C0;
            gate_n_m_r <= 1'b1;
            gate_n_s_r <= 1'b1;
            req_m_r <= '1;
            req_s_r <= '1;
        end else begin
            cst_m_r <= PROCESSOR_PKG_CSTATE;
            cst_s_r <= cst_m_r;
            gate_n_m_r <= PROCESSOR_DEEP_IDLE_GATE_N;
            gate_n_s_r <= gate_n_m_r;
            req_m_r <= CRYSTAL_CLKREQ;
            req_s_r <= req_m_r;
        end
    end

    // a code caught mid-change can decode as a false level; only a code seen
    // on two edges in a row is used, at the cost of two cycles of latency
    logic [slpc_pkg::CSTATE_W-1:0] cst_q_r, cst_ok_r;

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            cst_q_r <= slpc_pkg::CSTATE_C0;
            cst_ok_r <= slpc_pkg::CSTATE_C0;
        end else begin
            cst_q_r <= cst_s_r;
            if (cst_s_r == cst_q_r) begin
                cst_ok_r <= cst_s_r;
            end
        end
    end

    logic deep_c6, deep_c10, floor_ok, leave_floor;
    // the processor's own gate pin confirms c10 before the floor is entered
    assign deep_c6 = cst_ok_r >= slpc_pkg::CSTATE_C6;
    assign deep_c10 = (cst_ok_r >= slpc_pkg::CSTATE_C10) && !gate_n_s_r;
    assign floor_ok = deep_c10 && !WAKE_REQ;
    assign leave_floor = !floor_ok;

    // ********************************************************
    // level state machine
    // ********************************************************
    slpc_pkg::slpc_state_type state_r, state_nxt;
    logic [CNT_W-1:0] restore_cnt_r;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            slpc_pkg::ST_LEVEL_ONE: begin
                if (deep_c6) begin
                    state_nxt = slpc_pkg::ST_LEVEL_TWO;
                end
            end
            slpc_pkg::ST_LEVEL_TWO: begin
                if (!deep_c6) begin
                    state_nxt = slpc_pkg::ST_LEVEL_ONE;
                end else if (floor_ok) begin
                    state_nxt = slpc_pkg::ST_LEVEL_THREE;
                end
            end
            slpc_pkg::ST_LEVEL_THREE: begin
                if (leave_floor) begin
                    state_nxt = slpc_pkg::ST_EXIT;
                end
            end
            slpc_pkg::ST_EXIT: begin
                if (restore_cnt_r == CNT_LAST) begin
                    state_nxt = slpc_pkg::ST_LEVEL_ONE;
                end
            end
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            state_r <= slpc_pkg::ST_LEVEL_ONE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // clocks need time to settle; controllers wait the whole restore window
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            restore_cnt_r <= '0;
        end else if (state_r != slpc_pkg::ST_EXIT) begin
            restore_cnt_r <= '0;
        end else if (restore_cnt_r != CNT_LAST) begin
            restore_cnt_r <= restore_cnt_r + CNT_W'(1);
        end
    end

    // ********************************************************
    // shared resource outputs
    // ********************************************************
    logic in_floor_nxt, root_off_nxt, reference_crystal_ok;
    assign in_floor_nxt = state_nxt == slpc_pkg::ST_LEVEL_THREE;
    assign root_off_nxt = (state_nxt == slpc_pkg::ST_LEVEL_TWO) || in_floor_nxt;
    // every other consumer must have dropped its request
    assign reference_crystal_ok = in_floor_nxt && deep_c10 && (req_s_r == '0);

    logic [1:0] level_r;
    logic link_l1_r, main_off_r, oc_off_r, reference_crystal_off_r, floor_n_r, grant_r;

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            level_r <= slpc_pkg::LEVEL_ONE;
            link_l1_r <= 1'b0;
            main_off_r <= 1'b0;
            oc_off_r <= 1'b0;
            grant_r <= 1'b1;
        end else begin
            unique case (state_nxt)
                slpc_pkg::ST_LEVEL_ONE: level_r <= slpc_pkg::LEVEL_ONE;
                slpc_pkg::ST_LEVEL_TWO: level_r <= slpc_pkg::LEVEL_TWO;
                slpc_pkg::ST_LEVEL_THREE: level_r <= slpc_pkg::LEVEL_THREE;
                slpc_pkg::ST_EXIT: level_r <= slpc_pkg::LEVEL_EXIT;
            endcase
            link_l1_r <= state_nxt != slpc_pkg::ST_EXIT;
            main_off_r <= root_off_nxt;
            oc_off_r <= root_off_nxt;
            grant_r <= (state_nxt == slpc_pkg::ST_LEVEL_ONE)
                || (state_nxt == slpc_pkg::ST_LEVEL_TWO);
        end
    end

    // crystal and indicator reset to running/high, the s0 value
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            reference_crystal_off_r <= 1'b0;
            floor_n_r <= 1'b1;
        end else begin
            reference_crystal_off_r <= reference_crystal_ok;
            floor_n_r <= !in_floor_nxt;
        end
    end

    // ********************************************************
    // per-interface and per-lane gating
    // ********************************************************
    logic unit_allow;
    assign unit_allow = link_l1_r;

    for (genvar i = 0; i < NUM_IF; i++) begin : g_if
        slpc_idle_gate #(.QUAL_CYC(IDLE_QUAL_CYC)) u_gate (
            .clk_sys(CLK_SYS),
            .rst_n(RST_N),
            .idle(IF_IDLE[i]),
            .allow(unit_allow),
            .gate_off(IF_PLL_OFF[i])
        );
    end

    for (genvar j = 0; j < NUM_LANES; j++) begin : g_lane
        slpc_idle_gate #(.QUAL_CYC(IDLE_QUAL_CYC)) u_gate (
            .clk_sys(CLK_SYS),
            .rst_n(RST_N),
            .idle(LANE_IDLE[j]),
            .allow(unit_allow),
            .gate_off(LANE_POWER_GATE[j])
        );
    end

    assign LOW_POWER_LEVEL = level_r;
    assign CHIP_LINK_L1_ALLOW = link_l1_r;
    assign MAIN_PLL_OFF = main_off_r;
    assign OVERCLOCK_PLL_OFF = oc_off_r;
    assign REFERENCE_CRYSTAL_OFF = reference_crystal_off_r;
    assign IDLE_FLOOR_INDICATOR_N = floor_n_r;
    assign RESUME_GRANT = grant_r;

    // ********************************************************
    // checks
    // ********************************************************
    reference_crystal_gate_cond_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        $rose(reference_crystal_off_r) |-> $past(deep_c10) && $past(req_s_r) == '0)
        else $error("crystal gated without c10 and idle requests");
    reference_crystal_req_drop_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        (req_s_r != '0) |=> !reference_crystal_off_r)
        else $error("crystal stayed off with a request pending");
    floor_plls_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        !floor_n_r |-> main_off_r && oc_off_r && level_r == slpc_pkg::LEVEL_THREE)
        else $error("idle floor without root plls off");
    root_level_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        main_off_r |-> level_r == slpc_pkg::LEVEL_TWO || level_r == slpc_pkg::LEVEL_THREE)
        else $error("root plls off outside levels two and three");
    enter_two_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        state_r == slpc_pkg::ST_LEVEL_ONE && deep_c6 |=> main_off_r && oc_off_r)
        else $error("level two not entered on c6");
    indicator_s0_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        !deep_c10 |=> floor_n_r)
        else $error("indicator low outside c10");
    exit_order_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        state_r == slpc_pkg::ST_LEVEL_THREE && leave_floor
        |=> floor_n_r && !reference_crystal_off_r && !main_off_r && !grant_r)
        else $error("floor exit did not restore clocks first");
    exit_bound_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        $rose(state_r == slpc_pkg::ST_EXIT) |-> !grant_r ##[1:EXIT_MAX] grant_r)
        else $error("controllers not resumed after restore window");
    link_l1_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        state_r == slpc_pkg::ST_LEVEL_ONE && $past(RST_N) |-> link_l1_r)
        else $error("link l1 not allowed at level one");

    reach_two_c: cover property (@(posedge CLK_SYS) disable iff (!RST_N)
        state_r == slpc_pkg::ST_LEVEL_TWO);
    reach_floor_c: cover property (@(posedge CLK_SYS) disable iff (!RST_N)
        !floor_n_r);
    reference_crystal_off_c: cover property (@(posedge CLK_SYS) disable iff (!RST_N)
        $rose(reference_crystal_off_r));
    exit_done_c: cover property (@(posedge CLK_SYS) disable iff (!RST_N)
        $fell(state_r == slpc_pkg::ST_EXIT));

endmodule : slpc_top

/* File: slpc_proc_model.sv */
// partner model: processor package c-state code and its deep idle gate pin
// assumes the bench sets a goal c-state; the model moves on the system clock
`timescale 1ns/100ps
module slpc_proc_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] goal_cstate,
    input wire logic slow,
    output logic [3:0] cstate,
    output logic gate_n
);
    // ********************************************************
    // package state and gate pin
    // ********************************************************
    logic [3:0] lag_r;

    // slow mode lets the gate pin trail the c-state code by an extra cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cstate <= slpc_pkg::CSTATE_C0;
            lag_r <= slpc_pkg::CSTATE_C0;
            gate_n <= 1'b1;
        end else begin
            cstate <= goal_cstate;
            lag_r <= slow ? cstate : goal_cstate;
            gate_n <= !(lag_r >= slpc_pkg::CSTATE_C10);
        end
    end
endmodule : slpc_proc_model

/* File: test_slpc_top.sv */
// self-checking bench of the s0 low-power level controller
// assumes short restore and qualify counts; processor side is the partner model
`timescale 1ns/100ps
module test_slpc_top;
    // ********************************************************
    // signals and design under test
    // ********************************************************
    localparam int RCYC = 4;
    localparam int QCYC = 2;
    logic clk_sys, rst_n, wake_req, slow, gate_n, l1_allow, main_off, oc_off;
    logic reference_crystal_off, floor_n, grant;
    logic [3:0] goal_cstate, cstate, clkreq, if_idle, if_pll_off;
    logic [7:0] lane_idle, lane_gate;
    logic [1:0] level;
    logic [31:0] seed;
    int fails, samples_checked;

    slpc_top #(.RESTORE_CYC(RCYC), .IDLE_QUAL_CYC(QCYC)) dut (.CLK_SYS(clk_sys),
        .RST_N(rst_n), .PROCESSOR_PKG_CSTATE(cstate), .PROCESSOR_DEEP_IDLE_GATE_N(gate_n),
        .CRYSTAL_CLKREQ(clkreq), .IF_IDLE(if_idle), .LANE_IDLE(lane_idle),
        .WAKE_REQ(wake_req), .LOW_POWER_LEVEL(level), .CHIP_LINK_L1_ALLOW(l1_allow),
        .IF_PLL_OFF(if_pll_off), .LANE_POWER_GATE(lane_gate), .MAIN_PLL_OFF(main_off),
        .OVERCLOCK_PLL_OFF(oc_off), .REFERENCE_CRYSTAL_OFF(reference_crystal_off),
        .IDLE_FLOOR_INDICATOR_N(floor_n), .RESUME_GRANT(grant));
    slpc_proc_model cpu (.clk(clk_sys), .rst_n(rst_n), .goal_cstate(goal_cstate),
        .slow(slow), .cstate(cstate), .gate_n(gate_n));

    // ********************************************************
    // helpers
    // ********************************************************
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift

    // plls stay off in levels two and three only
    function automatic logic exp_pll(input logic [1:0] lv);
        return (lv == slpc_pkg::LEVEL_TWO) || (lv == slpc_pkg::LEVEL_THREE);
    endfunction : exp_pll

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : cyc

    task automatic check_level(input logic [1:0] lv, input logic [3:0] req);
        chk(16'(level), 16'(lv));
        chk(16'({main_off, oc_off}), {14'h0, {2{exp_pll(lv)}}});
        chk(16'(reference_crystal_off), 16'(lv == slpc_pkg::LEVEL_THREE && req == 4'h0));
        chk(16'(floor_n), 16'(lv != slpc_pkg::LEVEL_THREE));
        chk(16'(l1_allow), 16'(lv != slpc_pkg::LEVEL_EXIT));
        chk(16'(grant), 16'(lv == slpc_pkg::LEVEL_ONE || lv == slpc_pkg::LEVEL_TWO));
    endtask : check_level

    task automatic go(input logic [3:0] cs, input logic [3:0] req);
        @(posedge clk_sys);
        goal_cstate <= cs;
        clkreq <= req;
    endtask : go

    task automatic stop_test;
        $display("comparisons %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test

    // ********************************************************
    // clock, watchdog and tests
    // ********************************************************
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // whole run is under two hundred cycles; allow ample margin
    initial begin
        #20000;
        fails++;
        stop_test();
    end

    initial begin
        fails = 0;
        samples_checked = 0;
        seed = 32'h10AB191D;
        rst_n = 1'b0;
        wake_req = 1'b0;
        slow = 1'b0;
        goal_cstate = slpc_pkg::CSTATE_C0;
        clkreq = 4'h0;
        if_idle = 4'h0;
        lane_idle = 8'h00;
        cyc(5);
        chk(16'({floor_n, reference_crystal_off}), 16'h0002);
        @(posedge clk_sys);
        rst_n <= 1'b1;
        cyc(6);
        check_level(slpc_pkg::LEVEL_ONE, 4'h0);
        $display("test reset done");
        // corner patterns first, then random idle masks
        for (int i = 0; i < 8; i++) begin
            seed = xorshift(seed);
            @(posedge clk_sys);
            if_idle <= (i == 0) ? 4'hF : (i == 1) ? 4'h0 : seed[3:0];
            lane_idle <= (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : seed[11:4];
            cyc(QCYC + 6);
            chk(16'(if_pll_off), 16'(if_idle));
            chk(16'(lane_gate), 16'(lane_idle));
        end
        $display("test unit gating done");
        go(slpc_pkg::CSTATE_C6, 4'h0);
        cyc(7);
        check_level(slpc_pkg::LEVEL_TWO, 4'h0);
        go(slpc_pkg::CSTATE_C0, 4'h0);
        cyc(7);
        check_level(slpc_pkg::LEVEL_ONE, 4'h0);
        go(slpc_pkg::CSTATE_C6, 4'h5);
        cyc(7);
        check_level(slpc_pkg::LEVEL_TWO, 4'h5);
        $display("test levels one two done");
        @(posedge clk_sys);
        slow <= 1'b1;
        if_idle <= 4'hF;
        lane_idle <= 8'hFF;
        go(slpc_pkg::CSTATE_C10, 4'h5);
        cyc(10);
        check_level(slpc_pkg::LEVEL_THREE, 4'h5);
        go(slpc_pkg::CSTATE_C10, 4'h0);
        cyc(6);
        check_level(slpc_pkg::LEVEL_THREE, 4'h0);
        go(slpc_pkg::CSTATE_C10, 4'h8);
        cyc(6);
        check_level(slpc_pkg::LEVEL_THREE, 4'h8);
        $display("test idle floor done");
        @(posedge clk_sys);
        wake_req <= 1'b1;
        goal_cstate <= slpc_pkg::CSTATE_C0;
        cyc(1);
        check_level(slpc_pkg::LEVEL_EXIT, 4'h8);
        // unit gates see the withdrawn allow one edge after the level moves
        cyc(1);
        chk(16'({if_pll_off, lane_gate}), 16'h0000);
        cyc(RCYC + 7);
        check_level(slpc_pkg::LEVEL_ONE, 4'h8);
        @(posedge clk_sys);
        wake_req <= 1'b0;
        $display("test wake exit done");
        go(slpc_pkg::CSTATE_C6, 4'h0);
        cyc(7);
        @(posedge clk_sys);
        rst_n <= 1'b0;
        cyc(2);
        chk(16'({floor_n, reference_crystal_off, main_off, level}), 16'h0011);
        @(posedge clk_sys);
        rst_n <= 1'b1;
        cyc(8);
        check_level(slpc_pkg::LEVEL_TWO, 4'h0);
        $display("test mid-run reset done");
        stop_test();
    end
endmodule : test_slpc_top
